// *** design/psc_pkg.sv ***
package psc_pkg;

    // APB byte addresses of the registers.
    localparam logic [7:0] ADDR_GATE1    = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_DIVIDER_CONTROL   = 8'h04;
    localparam logic [7:0] ADDR_RESETCTL = 8'h08;
    localparam logic [7:0] ADDR_PWRCFG   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;

    // Module gate register layout.
    localparam int          GATE_TIMER1  = 11;
    localparam int          GATE_ENCODER = 10;
    localparam int          GATE_PWM     = 9;
    localparam int          GATE_I2C     = 7;
    localparam int          GATE_UART2   = 6;
    localparam int          GATE_UART1   = 5;
    localparam int          GATE_SPI2    = 4;
    localparam int          GATE_SPI1    = 3;
    localparam int          GATE_ADC     = 0;
    localparam logic [15:0] GATE1_MASK   = 16'h0EF9;
    localparam logic [15:0] GATE1_RESET  = 16'h0000;

    // Clock divider control layout.
    localparam int          CLOCK_DIVIDER_CONTROL_ROI   = 15;
    localparam int          CLOCK_DIVIDER_CONTROL_RATIO = 12;
    localparam int          CLOCK_DIVIDER_CONTROL_CPU_SLOWDOWN_EN = 11;
    localparam logic [15:0] CLOCK_DIVIDER_CONTROL_MASK  = 16'hF800;
    localparam logic [15:0] CLOCK_DIVIDER_CONTROL_RESET = 16'h0000;

    // Reset control layout.
    localparam int          RESETCTL_KEEP  = 8;
    localparam logic [15:0] RESETCTL_MASK  = 16'h0100;
    localparam logic [15:0] RESETCTL_RESET = 16'h0000;

    // Power configuration layout: low power regulator, watchdog and monitor enables.
    localparam int          PWRCFG_LPWR  = 0;
    localparam int          PWRCFG_WDT   = 1;
    localparam int          PWRCFG_FAILSAFE_CLOCK_MONITOR  = 2;
    localparam logic [15:0] PWRCFG_MASK  = 16'h0007;
    localparam logic [15:0] PWRCFG_RESET = 16'h0000;

    // Power save operands.
    localparam logic        OPERAND_SLEEP = 1'b0;
    localparam logic        OPERAND_IDLE  = 1'b1;

    // Cycles from wake to CPU restart, within the 2 to 4 cycle window.
    localparam logic [1:0]  RESUME_CYCLES = 2'h2;
    // Module gate change lands one instruction cycle after the write.
    localparam int          GATE_DELAY    = 1;

    typedef enum logic [1:0] { PSC_RUN, PSC_SLEEP, PSC_IDLE, PSC_RESUME } psc_state_e;

    typedef struct packed {
        logic        cpu_clk_en;
        logic        sys_osc_en;
        logic        low_power_rc_clock_en;
        logic        failsafe_clock_monitor_run;
        logic        wdt_clear;
        logic        periph_run;
        logic        idle_active;
        logic [1:0]  reg_mode;
    } psc_ctrl_s;

endpackage

// *** design/psc_power_ctrl.sv ***
// Overview of operation
// - power save operand 0 enters Sleep, operand 1 enters Idle.
// - Sleep stops the system oscillator and the fail-safe monitor.
// - In Sleep the RC clock runs while the watchdog is enabled.
// - Watchdog is cleared when entering Sleep or Idle.
// - Sleep disables system clocked peripherals; external clocked ones continue (here Sleep forces all PERIPH_CLK_EN bits low).
// - Enabled interrupt, reset or watchdog time-out wakes Sleep or Idle.
// - After Sleep the CPU restarts on the clock source it had before.
// - Regulators standby in Sleep unless keep-active bit is set.
// - Low power and keep-active bits choose one of four sleep modes.
// - Idle stops the CPU; peripherals keep running unless disabled.
// - In Idle the RC clock runs if watchdog or fail-safe monitor enabled.
// - CPU resumes two to four cycles after Idle wake.
// - Each peripheral's stop-in-idle bit halts it during Idle.
// - Interrupt during the power save instruction wakes after entry completes.
// - Doze slows CPU clock only; peripherals keep full speed in step.
// - Doze enable bit turns on Doze.
// - Three-bit ratio selects eight ratios 1:1 to 1:128, default 1:1.
// - Recover-on-interrupt set makes interrupts restore full CPU speed.
// - Module gate bit stops all clocks to that peripheral.
// - Peripheral enabled only if gate clear and present; enabled after reset.
// - Gate changes take effect one instruction cycle after the write.
// - Gate bits: timer1 11, encoder 10, pwm 9, i2c 7, uarts 6/5, spi 4/3, adc 0.
`timescale 1ns/100ps
module psc_power_ctrl
    import psc_pkg::*;
#(
    parameter logic [15:0] PRESENT_MASK = 16'h0EF9
)
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        POWER_SAVE_INSTR,
    input  wire logic        POWER_SAVE_OPERAND,
    input  wire logic        IRQ_PENDING,
    input  wire logic        WDT_TIMEOUT,
    input  wire logic [15:0] STOP_IN_IDLE,
    output logic             CPU_CLK_EN,
    output logic             SYS_OSC_EN,
    output logic             LOW_POWER_RC_CLOCK_EN,
    output logic             FAILSAFE_CLOCK_MONITOR_RUN,
    output logic             WDT_CLEAR,
    output logic             REG_STANDBY,
    output logic             REG_LOW_POWER,
    output logic [15:0]      PERIPH_CLK_EN,
    output logic             CPU_RESUME
);

    psc_state_e  state_q;
    logic [15:0] gate_q;
    logic [15:0] gate_eff_q;
    logic [15:0] clock_divider_control_q;
    logic [15:0] resetctl_q;
    logic [15:0] pwrcfg_q;
    logic [1:0]  resume_cnt_q;
    logic [6:0]  doze_cnt_q;
    logic        doze_tick;
    logic        full_speed_q;
    logic        pend_q;
    logic        wr_en;
    logic        rd_en;
    logic        wake;

    // Ratio code n divides by 2**n; the compare limit is one less.
    function automatic logic [6:0] doze_limit(input logic [2:0] code);
        doze_limit = 7'((8'h01 << code) - 8'h01);
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == ADDR_GATE1) || (a == ADDR_CLOCK_DIVIDER_CONTROL) || (a == ADDR_RESETCTL)
                  || (a == ADDR_PWRCFG) || (a == ADDR_STATUS);
    endfunction

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;
    // A reset clears state_q asynchronously, so only the interrupt and watchdog
    // wake terms appear here.
    assign wake  = IRQ_PENDING || WDT_TIMEOUT;

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            gate_q     <= GATE1_RESET;
            clock_divider_control_q   <= CLOCK_DIVIDER_CONTROL_RESET;
            resetctl_q <= RESETCTL_RESET;
            pwrcfg_q   <= PWRCFG_RESET;
        end
        else if (wr_en)
        begin
            case (PADDR)
                ADDR_GATE1:    gate_q     <= PWDATA[15:0] & GATE1_MASK;
                ADDR_CLOCK_DIVIDER_CONTROL:   clock_divider_control_q   <= PWDATA[15:0] & CLOCK_DIVIDER_CONTROL_MASK;
                ADDR_RESETCTL: resetctl_q <= PWDATA[15:0] & RESETCTL_MASK;
                ADDR_PWRCFG:   pwrcfg_q   <= PWDATA[15:0] & PWRCFG_MASK;
                default:       gate_q     <= gate_q;
            endcase
        end
    end

    // Read data is prepared in the setup cycle so the access phase needs no wait.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !known_addr(PADDR);
            if (rd_en)
            begin
                case (PADDR)
                    ADDR_GATE1:    PRDATA <= {16'h0000, gate_q};
                    ADDR_CLOCK_DIVIDER_CONTROL:   PRDATA <= {16'h0000, clock_divider_control_q};
                    ADDR_RESETCTL: PRDATA <= {16'h0000, resetctl_q};
                    ADDR_PWRCFG:   PRDATA <= {16'h0000, pwrcfg_q};
                    ADDR_STATUS:   PRDATA <= {28'h000_0000, full_speed_q, CPU_CLK_EN,
                                              state_q};
                    default:       PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // The power state machine.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_q      <= PSC_RUN;
            resume_cnt_q <= 2'h0;
            pend_q       <= 1'b0;
        end
        else
        begin
            case (state_q)
                PSC_RUN:
                begin
                    if (POWER_SAVE_INSTR)
                    begin
                        // An interrupt here is held and wakes the block right after entry.
                        pend_q  <= IRQ_PENDING;
                        state_q <= (POWER_SAVE_OPERAND == OPERAND_IDLE) ? PSC_IDLE
                                                                         : PSC_SLEEP;
                    end
                end
                PSC_SLEEP, PSC_IDLE:
                begin
                    if (wake || pend_q)
                    begin
                        pend_q       <= 1'b0;
                        resume_cnt_q <= RESUME_CYCLES;
                        state_q      <= PSC_RESUME;
                    end
                end
                PSC_RESUME:
                begin
                    if (resume_cnt_q == 2'h1)
                        state_q <= PSC_RUN;
                    resume_cnt_q <= resume_cnt_q - 2'h1;
                end
                default: state_q <= PSC_RUN;
            endcase
        end
    end

    // Doze divider: a tick every 2**n cycles gates the CPU clock enable.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            doze_cnt_q <= 7'h00;
        else if (doze_tick)
            doze_cnt_q <= 7'h00;
        else
            doze_cnt_q <= doze_cnt_q + 7'h01;
    end
    assign doze_tick = (doze_cnt_q >= doze_limit(clock_divider_control_q[CLOCK_DIVIDER_CONTROL_RATIO +: 3]));

    // Recovery flag: set by interrupt when enabled, cleared when software rewrites the
    // divider control. Set wins over the clear.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            full_speed_q <= 1'b0;
        else if (IRQ_PENDING && clock_divider_control_q[CLOCK_DIVIDER_CONTROL_ROI])
            full_speed_q <= 1'b1;
        else if (wr_en && PADDR == ADDR_CLOCK_DIVIDER_CONTROL)
            full_speed_q <= 1'b0;
    end

    // Gate changes take effect one cycle after the register update.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            gate_eff_q <= GATE1_RESET;
        else
            gate_eff_q <= gate_q;
    end

    // Output flops. The oscillator choice is never altered here, so the CPU comes back on
    // the source it left.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CPU_CLK_EN    <= 1'b1;
            SYS_OSC_EN    <= 1'b1;
            LOW_POWER_RC_CLOCK_EN       <= 1'b0;
            FAILSAFE_CLOCK_MONITOR_RUN      <= 1'b0;
            WDT_CLEAR     <= 1'b0;
            REG_STANDBY   <= 1'b0;
            REG_LOW_POWER <= 1'b0;
            PERIPH_CLK_EN <= 16'h0000;
            CPU_RESUME    <= 1'b0;
        end
        else
        begin
            CPU_CLK_EN    <= (state_q == PSC_RUN) && !(POWER_SAVE_INSTR)
                          && (!clock_divider_control_q[CLOCK_DIVIDER_CONTROL_CPU_SLOWDOWN_EN] || full_speed_q || doze_tick);
            SYS_OSC_EN    <= (state_q != PSC_SLEEP);
            FAILSAFE_CLOCK_MONITOR_RUN      <= (state_q != PSC_SLEEP) && pwrcfg_q[PWRCFG_FAILSAFE_CLOCK_MONITOR];
            LOW_POWER_RC_CLOCK_EN       <= pwrcfg_q[PWRCFG_WDT]
                          || ((state_q != PSC_SLEEP) && pwrcfg_q[PWRCFG_FAILSAFE_CLOCK_MONITOR]);
            WDT_CLEAR     <= (state_q == PSC_RUN) && POWER_SAVE_INSTR
                          && pwrcfg_q[PWRCFG_WDT];
            REG_STANDBY   <= (state_q == PSC_SLEEP) && !resetctl_q[RESETCTL_KEEP];
            REG_LOW_POWER <= (state_q == PSC_SLEEP) && pwrcfg_q[PWRCFG_LPWR];
            PERIPH_CLK_EN <= PRESENT_MASK & GATE1_MASK & ~gate_eff_q
                          & ((state_q == PSC_IDLE) ? ~STOP_IN_IDLE : 16'hFFFF)
                          & ((state_q == PSC_SLEEP) ? 16'h0000 : 16'hFFFF);
            CPU_RESUME    <= (state_q == PSC_RESUME) && (resume_cnt_q == 2'h1);
        end
    end

    a_sleep_osc_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state_q == PSC_SLEEP |=> !SYS_OSC_EN && !FAILSAFE_CLOCK_MONITOR_RUN)
        else $error("oscillator running in sleep");
    a_enter_mode: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state_q == PSC_RUN && POWER_SAVE_INSTR |=>
            state_q == (POWER_SAVE_OPERAND ? PSC_IDLE : PSC_SLEEP))
        else $error("wrong power mode entered");
    a_wdt_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state_q == PSC_RUN && POWER_SAVE_INSTR && pwrcfg_q[PWRCFG_WDT] |=> WDT_CLEAR)
        else $error("watchdog not cleared on entry");
    a_wake_up: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state_q == PSC_SLEEP || state_q == PSC_IDLE) && wake |=> state_q == PSC_RESUME)
        else $error("no wake on event");
    sequence s_resume;
        state_q == PSC_RESUME ##1 state_q == PSC_RESUME ##1 state_q == PSC_RUN;
    endsequence
    a_resume_time: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(state_q == PSC_RESUME) |-> s_resume)
        else $error("resume not two cycles");
    a_deferred_irq: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state_q == PSC_RUN && POWER_SAVE_INSTR && IRQ_PENDING |=> ##1 state_q == PSC_RESUME)
        else $error("deferred interrupt lost");
    a_standby_sel: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state_q == PSC_SLEEP |=> REG_STANDBY == !$past(resetctl_q[RESETCTL_KEEP]))
        else $error("regulator standby wrong");
    a_gate_delay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state_q == PSC_RUN && $changed(gate_q) |-> ##1 $stable(PERIPH_CLK_EN)
            ##1 PERIPH_CLK_EN == (PRESENT_MASK & GATE1_MASK & ~$past(gate_q, 2)))
        else $error("gate change timing wrong");
    a_sleep_periph: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state_q == PSC_SLEEP |=> PERIPH_CLK_EN == 16'h0000)
        else $error("peripheral clocked in sleep");

endmodule

// *** test/psc_cpu_model.sv ***
`timescale 1ns/100ps
module psc_cpu_model
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cpu_clk_en,
    input  wire logic        wdt_clear,
    output logic             instr,
    output logic             operand,
    output logic [15:0]      ticks,
    output logic [7:0]       clears
);
    initial
    begin
        instr = 1'b0;
        operand = 1'b0;
    end

    // The core issues the power save instruction as a one-cycle pulse with its operand.
    task automatic exec(input logic op);
        @(posedge clk);
        instr <= 1'b1;
        operand <= op;
        @(posedge clk);
        instr <= 1'b0;
    endtask

    // Counting enabled core cycles lets the bench judge doze ratios without probing inside.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ticks <= 16'h0000;
            clears <= 8'h00;
        end
        else
        begin
            ticks <= ticks + {15'h0000, cpu_clk_en};
            clears <= clears + {7'h00, wdt_clear};
        end
    end
endmodule

// *** test/power_save_clock_gating_tb.sv ***
`timescale 1ns/100ps
module power_save_clock_gating_tb;
    import psc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, irq = 1'b0, wto = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, instr, operand, cpu_en, osc_en, low_power_rc_clock_en, failsafe_clock_monitor_run;
    logic        wclr, reg_sb, reg_lp, resume, lp, keep, w;
    logic [15:0] stop_in_idle = 16'h0000, pclk_en, ticks, t0, g, exp_en;
    logic [7:0]  clears, c0;
    int          mismatches = 0, checks = 0, cycles = 0, k;
    logic [7:0]  ra [5] = '{ADDR_GATE1, ADDR_CLOCK_DIVIDER_CONTROL, ADDR_RESETCTL, ADDR_PWRCFG, ADDR_STATUS};
    logic [31:0] rv [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                            32'h0000_0004};

    always #4 clk = ~clk;

    psc_power_ctrl dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .POWER_SAVE_INSTR(instr), .POWER_SAVE_OPERAND(operand),
        .IRQ_PENDING(irq), .WDT_TIMEOUT(wto), .STOP_IN_IDLE(stop_in_idle), .CPU_CLK_EN(cpu_en),
        .SYS_OSC_EN(osc_en), .LOW_POWER_RC_CLOCK_EN(low_power_rc_clock_en), .FAILSAFE_CLOCK_MONITOR_RUN(failsafe_clock_monitor_run), .WDT_CLEAR(wclr),
        .REG_STANDBY(reg_sb), .REG_LOW_POWER(reg_lp), .PERIPH_CLK_EN(pclk_en),
        .CPU_RESUME(resume));

    psc_cpu_model cpu (.clk(clk), .rst_n(rst_n), .cpu_clk_en(cpu_en), .wdt_clear(wclr),
        .instr(instr), .operand(operand), .ticks(ticks), .clears(clears));

    function automatic logic [15:0] en_of(input logic [15:0] gate);
        return ~gate & GATE1_MASK;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request stays fully held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_resume(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (resume !== 1'b1 && n < 40);
    endtask

    task automatic doze_irq(input logic [31:0] v, input logic [15:0] exp);
        apb(1'b1, ADDR_CLOCK_DIVIDER_CONTROL, v);
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        step(4);
        t0 = ticks;
        step(16);
        chk("recovery ticks", t0 + exp, ticks);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial
    begin
        void'($urandom(5));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        step(2);
        exp_en = GATE1_MASK;
        chk("periph_clk_en", exp_en, pclk_en);
        foreach (ra[i])
        begin
            apb(1'b0, ra[i], 32'h0000_0000);
            chk("reset value", rv[i], rd);
        end
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0000_0000, rd);
        for (int i = 0; i < 6; i++)
        begin
            g = (i == 0) ? 16'hFFFF : 16'($urandom);
            apb(1'b1, ADDR_GATE1, {16'h0000, g});
            step(1);
            chk("gate hold", exp_en, pclk_en);
            step(1);
            exp_en = en_of(g);
            chk("periph_clk_en", exp_en, pclk_en);
            apb(1'b0, ADDR_GATE1, 32'h0000_0000);
            chk("gate read", {16'h0000, g & GATE1_MASK}, rd);
        end
        apb(1'b1, ADDR_PWRCFG, 32'h0000_0006);
        stop_in_idle <= 16'($urandom);
        c0 = clears;
        cpu.exec(OPERAND_IDLE);
        step(3);
        chk("idle cpu", 1'b0, cpu_en);
        chk("idle osc", 1'b1, osc_en);
        chk("idle low_power_rc_clock", 1'b1, low_power_rc_clock_en);
        chk("idle monitor", 1'b1, failsafe_clock_monitor_run);
        chk("idle pclk", exp_en & ~stop_in_idle, pclk_en);
        chk("idle wdt clear", c0 + 8'h01, clears);
        @(posedge clk);
        irq <= 1'b1;
        wait_resume(k);
        chk("resume delay", 1'b1, k >= 3 && k <= 5);
        @(posedge clk);
        irq <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            lp = i[0];
            keep = i[1];
            w = i[0] ^ i[1];
            apb(1'b1, ADDR_PWRCFG, {29'h0000_0000, 1'b1, w, lp});
            apb(1'b1, ADDR_RESETCTL, {23'h00_0000, keep, 8'h00});
            c0 = clears;
            cpu.exec(OPERAND_SLEEP);
            step(3);
            chk("sleep osc", 1'b0, osc_en);
            chk("sleep monitor", 1'b0, failsafe_clock_monitor_run);
            chk("sleep low_power_rc_clock", w, low_power_rc_clock_en);
            chk("sleep pclk", 16'h0000, pclk_en);
            chk("standby", !keep, reg_sb);
            chk("low power", lp, reg_lp);
            chk("sleep wdt clear", c0 + {7'h00, w}, clears);
            @(posedge clk);
            wto <= 1'b1;
            @(posedge clk);
            wto <= 1'b0;
            wait_resume(k);
            chk("timeout wake", 1'b1, resume);
            step(1);
            chk("restart clock", 1'b1, cpu_en & osc_en);
        end
        apb(1'b1, ADDR_PWRCFG, 32'h0000_0002);
        c0 = clears;
        irq <= 1'b1;
        cpu.exec(OPERAND_IDLE);
        wait_resume(k);
        chk("deferred wake", 1'b1, resume);
        chk("entry done", c0 + 8'h01, clears);
        @(posedge clk);
        irq <= 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            apb(1'b1, ADDR_CLOCK_DIVIDER_CONTROL, 32'h0000_0800 | (n << 12));
            step(4);
            t0 = ticks;
            step(4 << n);
            chk("doze ticks", t0 + 16'h0004, ticks);
            chk("doze pclk", exp_en, pclk_en);
        end
        doze_irq(32'h0000_F800, 16'h0010);
        doze_irq(32'h0000_3800, 16'h0002);
        tally_and_finish();
    end
endmodule
